// >>> hw/clk_en_div.sv
/*
 Clock enable divider: one-cycle pulse every DIV cycles while enabled.
 Assumes a single clock domain; DIV is at least 1.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_en_div #(
	parameter logic [7:0] DIV = 8'h02
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic run,
	output logic      pulse
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (!run || cnt_ff == DIV - 8'h01) begin
			nxt_cnt = 8'h00;
		end else begin
			nxt_cnt = cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// The pulse comes on the last count so a restart never shortens a period.
	assign pulse = run && (cnt_ff == DIV - 8'h01);
endmodule
`default_nettype wire

// >>> hw/low_power_clock_manager.sv
/*
 Low-power clock manager: halt-entered sleep states, clock gates, limp
 mode, peripheral clock enables and the PLL feedback divider register.
 Assumes the core gives a one-cycle halt pulse and that ext_irq and
 pll_lock arrive asynchronously; peripheral interrupts are synchronous.
*/
// Function
// - Halt enters the state chosen by mode field.
// - Light idle and light_sleep_state_b stop processor, memory clocks.
// - Deep stop also stops the system clock.
// - Deep stop gates bus, PLL, oscillator as selected.
// - Wait for PLL lock before waking from stop.
// - Only external interrupts wake deep stop.
// - Limp mode clocks processor from divided reference.
// - Limp sleep keeps peripherals except SDRAM, Ethernet.
// - Per-peripheral clock enables, writable any time.
// - PLL reference is the 16 MHz input.
// - Feedback divider sets multiplier 7.33 to 11.25.
// - System clock is half the core clock while the core runs.
`timescale 1ns/1ps
`default_nettype none
module low_power_clock_manager (
	input  wire logic                            ref_clk,
	input  wire logic                            arst_n,
	input  wire logic [lpcm_pkg::ADDR_W-1:0]     addr,
	input  wire logic [lpcm_pkg::DATA_W-1:0]     wdata,
	input  wire logic                            wr_stb,
	input  wire logic                            rd_stb,
	output logic      [lpcm_pkg::DATA_W-1:0]     rdata,
	input  wire logic                            halt_req,
	input  wire logic                            ext_irq,
	input  wire logic [lpcm_pkg::NUM_PERIPH-1:0] periph_irq,
	input  wire logic                            pll_lock,
	output logic                                 cpu_idle,
	output logic                                 cpu_clk_on,
	output logic                                 mem_clk_on,
	output logic                                 sys_clk_on,
	output logic                                 bus_clk_on,
	output logic                                 pll_on,
	output logic                                 osc_on,
	output logic                                 limp_sel,
	output logic                                 cpu_clk_en,
	output logic                                 sys_clk_en,
	output logic      [lpcm_pkg::NUM_PERIPH-1:0] periph_clk_on,
	output logic      [7:0]                      pll_fb_div
);
	typedef enum logic [5:0] {
		ST_RUN   = 6'h01,
		ST_LIGHT = 6'h02,
		ST_LIGHT_SLEEP_STATE_B  = 6'h04,
		ST_STOP  = 6'h08,
		ST_LOCK  = 6'h10,
		ST_WAKE  = 6'h20
	} pm_state_e;

	pm_state_e                       state_ff, nxt_state;
	logic [4:0]                      sleep_ctrl_ff, nxt_sleep_ctrl;
	logic [7:0]                      fb_div_ff, nxt_fb_div;
	logic [lpcm_pkg::NUM_PERIPH-1:0] periph_en_ff, nxt_periph_en;
	logic [1:0]                      stop_sel_ff, nxt_stop_sel;
	logic [lpcm_pkg::DATA_W-1:0]     rdata_ff, nxt_rdata;
	logic [2:0]                      irq_sync_ff, lock_sync_ff;
	logic                            irq_f_ff, lock_f_ff;
	logic                            nxt_irq_f, nxt_lock_f;
	logic                            cpu_idle_ff, cpu_on_ff, mem_on_ff, sys_on_ff;
	logic                            bus_on_ff, pll_on_ff, osc_on_ff, limp_ff;
	logic [lpcm_pkg::NUM_PERIPH-1:0] pclk_ff, nxt_pclk;
	logic                            nxt_idle, nxt_cpu_on, nxt_mem_on, nxt_sys_on;
	logic                            nxt_bus_on, nxt_pll_on, nxt_osc_on, nxt_limp;
	logic [lpcm_pkg::NUM_PERIPH-1:0] limp_mask;
	logic                            light_wake, sys_pulse, limp_pulse;
	logic                            limp_half_ff, nxt_limp_half;
	logic [7:0]                      wr_div;

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_comb begin
		nxt_irq_f  = (irq_sync_ff[1] == irq_sync_ff[2]) ? irq_sync_ff[2] : irq_f_ff;
		nxt_lock_f = (lock_sync_ff[1] == lock_sync_ff[2]) ? lock_sync_ff[2] : lock_f_ff;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_sync_ff  <= 3'h0;
			lock_sync_ff <= 3'h0;
			irq_f_ff     <= 1'b0;
			lock_f_ff    <= 1'b0;
		end else begin
			irq_sync_ff  <= {irq_sync_ff[1:0], ext_irq};
			lock_sync_ff <= {lock_sync_ff[1:0], pll_lock};
			irq_f_ff     <= nxt_irq_f;
			lock_f_ff    <= nxt_lock_f;
		end
	end

	// Register file. Out-of-range divider writes clamp, since the PLL
	// cannot lock outside its multiplier range.
	always_comb begin
		nxt_sleep_ctrl = sleep_ctrl_ff;
		nxt_fb_div     = fb_div_ff;
		nxt_periph_en  = periph_en_ff;
		nxt_rdata      = '0;
		wr_div         = wdata[7:0];
		if (wr_stb) begin
			unique case (addr)
				lpcm_pkg::OFS_SLEEP_CTRL: nxt_sleep_ctrl = wdata[4:0];
				lpcm_pkg::OFS_PLL_FB_DIV: begin
					if (wr_div < lpcm_pkg::PLL_FB_DIV_MIN) begin
						nxt_fb_div = lpcm_pkg::PLL_FB_DIV_MIN;
					end else if (wr_div > lpcm_pkg::PLL_FB_DIV_MAX) begin
						nxt_fb_div = lpcm_pkg::PLL_FB_DIV_MAX;
					end else begin
						nxt_fb_div = wr_div;
					end
				end
				lpcm_pkg::OFS_PERIPH_EN: nxt_periph_en = wdata[lpcm_pkg::NUM_PERIPH-1:0];
				default: ;
			endcase
		end
		if (rd_stb) begin
			unique case (addr)
				lpcm_pkg::OFS_SLEEP_CTRL: nxt_rdata[4:0] = sleep_ctrl_ff;
				lpcm_pkg::OFS_PLL_FB_DIV: nxt_rdata[7:0] = fb_div_ff;
				lpcm_pkg::OFS_PERIPH_EN:  nxt_rdata[lpcm_pkg::NUM_PERIPH-1:0] = periph_en_ff;
				lpcm_pkg::OFS_STATUS:     nxt_rdata[8:0] = {lock_f_ff, stop_sel_ff, state_ff};
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_ctrl_ff <= lpcm_pkg::SLEEP_CTRL_RST;
			fb_div_ff     <= lpcm_pkg::PLL_FB_DIV_RST;
			periph_en_ff  <= lpcm_pkg::PERIPH_EN_RST;
			rdata_ff      <= '0;
		end else begin
			sleep_ctrl_ff <= nxt_sleep_ctrl;
			fb_div_ff     <= nxt_fb_div;
			periph_en_ff  <= nxt_periph_en;
			rdata_ff      <= nxt_rdata;
		end
	end

	// Limp mode starves the SDRAM and Ethernet blocks, so their clocks and
	// interrupts are dropped there.
	always_comb begin
		limp_mask                          = '1;
		limp_mask[lpcm_pkg::PERIPH_SDRAM]  = ~nxt_sleep_ctrl[lpcm_pkg::LIMP_BIT];
		limp_mask[lpcm_pkg::PERIPH_ETH]    = ~nxt_sleep_ctrl[lpcm_pkg::LIMP_BIT];
		light_wake = irq_f_ff || (|(periph_irq & pclk_ff));
	end

	// Power state machine and the clock gates it drives.
	always_comb begin
		nxt_state    = state_ff;
		nxt_stop_sel = stop_sel_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (halt_req) begin
					unique case (sleep_ctrl_ff[lpcm_pkg::MODE_LSB +: 2])
						lpcm_pkg::MODE_STOP: begin
							nxt_state    = ST_STOP;
							nxt_stop_sel = sleep_ctrl_ff[lpcm_pkg::STOPSEL_LSB +: 2];
						end
						lpcm_pkg::MODE_LIGHT_SLEEP_STATE_B: nxt_state = ST_LIGHT_SLEEP_STATE_B;
						default:             nxt_state = ST_LIGHT;
					endcase
				end
			end
			ST_LIGHT, ST_LIGHT_SLEEP_STATE_B: begin
				if (light_wake) begin
					nxt_state = ST_RUN;
				end
			end
			ST_STOP: begin
				if (irq_f_ff) begin
					nxt_state = (stop_sel_ff >= lpcm_pkg::STOPSEL_PLL) ? ST_LOCK : ST_WAKE;
				end
			end
			ST_LOCK: begin
				if (lock_f_ff) begin
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: nxt_state = ST_RUN;
			default: nxt_state = ST_RUN;
		endcase

		nxt_idle   = (nxt_state != ST_RUN);
		nxt_cpu_on = (nxt_state == ST_RUN);
		nxt_mem_on = (nxt_state == ST_RUN);
		nxt_sys_on = !(nxt_state inside {ST_STOP, ST_LOCK});
		nxt_bus_on = !((nxt_state inside {ST_STOP, ST_LOCK})
			&& nxt_stop_sel != lpcm_pkg::STOPSEL_NONE);
		nxt_pll_on = !((nxt_state == ST_STOP)
			&& nxt_stop_sel >= lpcm_pkg::STOPSEL_PLL);
		nxt_osc_on = !((nxt_state == ST_STOP)
			&& nxt_stop_sel == lpcm_pkg::STOPSEL_OSC);
		nxt_limp   = nxt_sleep_ctrl[lpcm_pkg::LIMP_BIT];
		nxt_pclk   = (nxt_state inside {ST_STOP, ST_LOCK}) ? '0
			: (nxt_periph_en & limp_mask);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff    <= ST_RUN;
			stop_sel_ff <= lpcm_pkg::STOPSEL_NONE;
			cpu_idle_ff <= 1'b0;
			cpu_on_ff   <= 1'b1;
			mem_on_ff   <= 1'b1;
			sys_on_ff   <= 1'b1;
			bus_on_ff   <= 1'b1;
			pll_on_ff   <= 1'b1;
			osc_on_ff   <= 1'b1;
			limp_ff     <= 1'b0;
			pclk_ff     <= lpcm_pkg::PERIPH_EN_RST;
		end else begin
			state_ff    <= nxt_state;
			stop_sel_ff <= nxt_stop_sel;
			cpu_idle_ff <= nxt_idle;
			cpu_on_ff   <= nxt_cpu_on;
			mem_on_ff   <= nxt_mem_on;
			sys_on_ff   <= nxt_sys_on;
			bus_on_ff   <= nxt_bus_on;
			pll_on_ff   <= nxt_pll_on;
			osc_on_ff   <= nxt_osc_on;
			limp_ff     <= nxt_limp;
			pclk_ff     <= nxt_pclk;
		end
	end

	// The limp divider runs through sleep as well, since the system rate in
	// limp mode is taken from its pulses and must not stop in light idle.
	clk_en_div #(
		.DIV (lpcm_pkg::LIMP_DIV)
	) u_limp_div (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (limp_ff),
		.pulse   (limp_pulse)
	);

	clk_en_div #(
		.DIV (lpcm_pkg::SYS_DIV)
	) u_sys_div (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (sys_on_ff),
		.pulse   (sys_pulse)
	);

	// In limp mode the system enable takes every second core pulse, so the
	// two rates keep their two-to-one ratio and stay in phase.
	always_comb begin
		nxt_limp_half = limp_half_ff;
		if (!limp_ff) begin
			nxt_limp_half = 1'b0;
		end else if (limp_pulse) begin
			nxt_limp_half = ~limp_half_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			limp_half_ff <= 1'b0;
		end else begin
			limp_half_ff <= nxt_limp_half;
		end
	end

	assign cpu_clk_en    = cpu_on_ff && (limp_ff ? limp_pulse : 1'b1);
	assign sys_clk_en    = limp_ff ? (sys_on_ff && limp_pulse && limp_half_ff) : sys_pulse;
	assign rdata         = rdata_ff;
	assign cpu_idle      = cpu_idle_ff;
	assign cpu_clk_on    = cpu_on_ff;
	assign mem_clk_on    = mem_on_ff;
	assign sys_clk_on    = sys_on_ff;
	assign bus_clk_on    = bus_on_ff;
	assign pll_on        = pll_on_ff && !limp_ff;
	assign osc_on        = osc_on_ff;
	assign limp_sel      = limp_ff;
	assign periph_clk_on = pclk_ff;
	assign pll_fb_div    = fb_div_ff;

	AST_HALT_ENTERS: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_RUN && halt_req |=> state_ff != ST_RUN)
		else $error("Halt did not leave run.");
	AST_LIGHT_GATES: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff inside {ST_LIGHT, ST_LIGHT_SLEEP_STATE_B} |-> !cpu_clk_on && !mem_clk_on && sys_clk_on)
		else $error("Light sleep gating wrong.");
	AST_STOP_GATES: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_STOP |-> !cpu_clk_on && !mem_clk_on && !sys_clk_on && cpu_idle)
		else $error("Deep stop left a clock running.");
	AST_STOP_OSC: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_STOP && stop_sel_ff == lpcm_pkg::STOPSEL_OSC
		|-> !osc_on && !pll_on && !bus_clk_on)
		else $error("Stop selection not applied.");
	AST_LOCK_WAIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_LOCK && !lock_f_ff |=> state_ff == ST_LOCK)
		else $error("Woke before PLL lock.");
	AST_STOP_EXT_ONLY: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_STOP && !irq_f_ff |=> state_ff == ST_STOP)
		else $error("Deep stop woke without external interrupt.");
	AST_LIMP_MASK: assert property (@(posedge ref_clk) disable iff (!arst_n)
		limp_sel |-> !periph_clk_on[lpcm_pkg::PERIPH_SDRAM] && !periph_clk_on[lpcm_pkg::PERIPH_ETH])
		else $error("Limp mode clocks SDRAM or Ethernet.");
	AST_SYS_HALF: assert property (@(posedge ref_clk) disable iff (!arst_n)
		sys_clk_en |=> !sys_clk_en)
		else $error("System enable faster than half rate.");
	AST_SYS_ON_CORE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		sys_clk_en && cpu_clk_on |-> cpu_clk_en)
		else $error("System enable off a core edge.");
	AST_FB_RANGE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		pll_fb_div >= lpcm_pkg::PLL_FB_DIV_MIN && pll_fb_div <= lpcm_pkg::PLL_FB_DIV_MAX)
		else $error("Feedback divider out of range.");
	AST_WAKE_RUN: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == ST_WAKE |=> state_ff == ST_RUN ##1 cpu_clk_on && sys_clk_on)
		else $error("Wake did not restore run.");
endmodule
`default_nettype wire

// >>> hw/lpcm_pkg.sv
/*
 Shared constants of the low-power clock manager: register offsets,
 field positions, reset values, mode codes and divider counts.
 Assumes nothing of its surroundings.
*/
package lpcm_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          NUM_PERIPH      = 8;
	localparam logic [7:0]  OFS_SLEEP_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_PLL_FB_DIV  = 8'h04;
	localparam logic [7:0]  OFS_PERIPH_EN   = 8'h08;
	localparam logic [7:0]  OFS_STATUS      = 8'h0c;
	localparam int          MODE_LSB        = 0;
	localparam int          STOPSEL_LSB     = 2;
	localparam int          LIMP_BIT        = 4;
	localparam logic [1:0]  MODE_LIGHT      = 2'h0;
	localparam logic [1:0]  MODE_LIGHT_SLEEP_STATE_B       = 2'h1;
	localparam logic [1:0]  MODE_STOP       = 2'h2;
	localparam logic [1:0]  STOPSEL_NONE    = 2'h0;
	localparam logic [1:0]  STOPSEL_BUS     = 2'h1;
	localparam logic [1:0]  STOPSEL_PLL     = 2'h2;
	localparam logic [1:0]  STOPSEL_OSC     = 2'h3;
	localparam logic [4:0]  SLEEP_CTRL_RST  = 5'h00;
	localparam logic [7:0]  PLL_FB_DIV_MIN  = 8'h58;
	localparam logic [7:0]  PLL_FB_DIV_MAX  = 8'h87;
	localparam logic [7:0]  PLL_FB_DIV_RST  = 8'h6c;
	localparam logic [7:0]  PLL_FB_DIV_DEN  = 8'h0c;
	localparam logic [7:0]  PERIPH_EN_RST   = 8'hff;
	localparam int          PERIPH_SDRAM    = 0;
	localparam int          PERIPH_ETH      = 1;
	localparam int          REF_CLK_MHZ     = 16;
	localparam logic [7:0]  SYS_DIV         = 8'h02;
	localparam logic [7:0]  LIMP_DIV        = 8'h08;
endpackage

// >>> verif/low_power_clock_manager_tb.sv
/*
 Self-checking bench for the clock manager: register access, sleep
 entry and wake, limp mode and clock enables. Assumes the PLL lock model.
*/
`timescale 1ns/1ps
`default_nettype none
module low_power_clock_manager_tb;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic halt_req = 1'b0;
	logic ext_irq = 1'b0;
	logic [7:0] periph_irq = 8'h00;
	logic [31:0] rdata;
	logic pll_lock, cpu_idle, cpu_clk_on, mem_clk_on, sys_clk_on, bus_clk_on;
	logic pll_on, osc_on, limp_sel, cpu_clk_en, sys_clk_en;
	logic [7:0] periph_clk_on, pll_fb_div;
	logic [7:0] gv;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int c_cpu, c_sys;
	assign gv = {cpu_idle, cpu_clk_on, mem_clk_on, sys_clk_on,
		bus_clk_on, pll_on, osc_on, limp_sel};
	low_power_clock_manager u_low_power_clock_manager (.ref_clk(ref_clk), .arst_n(arst_n),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.halt_req(halt_req), .ext_irq(ext_irq), .periph_irq(periph_irq),
		.pll_lock(pll_lock), .cpu_idle(cpu_idle), .cpu_clk_on(cpu_clk_on),
		.mem_clk_on(mem_clk_on), .sys_clk_on(sys_clk_on), .bus_clk_on(bus_clk_on),
		.pll_on(pll_on), .osc_on(osc_on), .limp_sel(limp_sel), .cpu_clk_en(cpu_clk_en),
		.sys_clk_en(sys_clk_en), .periph_clk_on(periph_clk_on), .pll_fb_div(pll_fb_div));
	pll_lock_model u_pll_lock_model (.ref_clk(ref_clk), .arst_n(arst_n),
		.pll_on(pll_on), .pll_lock(pll_lock));
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic results;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// The ceiling is some forty times the expected run, so only a hang reaches it.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic halt;
		@(posedge ref_clk);
		halt_req <= 1'b1;
		@(posedge ref_clk);
		halt_req <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wait_idle(input logic v, input int lim);
		int n;
		n = 0;
		while (cpu_idle !== v && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk({31'h0, cpu_idle}, {31'h0, v});
	endtask
	task automatic cnt_en(input int n);
		c_cpu = 0;
		c_sys = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			if (cpu_clk_en === 1'b1) c_cpu++;
			if (sys_clk_en === 1'b1) c_sys++;
		end
	endtask
	initial begin
		logic [1:0] s;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		chk(gv, 8'h7e);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h6c);
		rd(8'h08, 32'hff);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'h40);
		rd(8'h04, 32'h58);
		wr(8'h04, 32'hff);
		rd(8'h04, 32'h87);
		wr(8'h04, 32'h60);
		rd(8'h04, 32'h60);
		chk(pll_fb_div, 8'h60);
		wr(8'h10, 32'hffffffff);
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		cnt_en(64);
		chk(c_cpu, 64);
		chk(c_sys, 32);
		// Light idle, light_sleep_state_b and the spare code that behaves as light idle.
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, (i == 2) ? 32'h3 : i);
			halt();
			chk(gv, 8'h9e);
			if (i == 0) begin
				wr(8'h08, 32'hfb);
				periph_irq <= 8'h04;
				repeat (10) @(posedge ref_clk);
				#1;
				chk(periph_clk_on, 8'hfb);
				chk(cpu_idle, 1'b1);
				wr(8'h08, 32'hff);
			end else if (i == 1) ext_irq <= 1'b1;
			else periph_irq <= 8'h04;
			wait_idle(1'b0, 20);
			chk(gv, 8'h7e);
			ext_irq <= 1'b0;
			periph_irq <= 8'h00;
			repeat (6) @(posedge ref_clk);
		end
		// Every stop clock selection, widest last.
		for (int i = 0; i < 4; i++) begin
			s = i;
			wr(8'h00, {s, 2'h2});
			halt();
			chk(gv, {4'h8, s == 0, s < 2, s < 3, 1'b0});
			// The lock level needs its synchroniser delay before status shows it.
			repeat (4) @(posedge ref_clk);
			rd(8'h0c, {s < 2, s, 6'h08});
			periph_irq <= 8'h04;
			repeat (10) @(posedge ref_clk);
			#1;
			chk(cpu_idle, 1'b1);
			periph_irq <= 8'h00;
			ext_irq <= 1'b1;
			repeat (8) @(posedge ref_clk);
			#1;
			if (s >= 2) chk({osc_on, pll_on, sys_clk_on}, 3'b110);
			wait_idle(1'b0, 200);
			chk(gv, 8'h7e);
			ext_irq <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
		wr(8'h00, 32'h10);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(gv, 8'h7b);
		chk(periph_clk_on, 8'hfc);
		cnt_en(64);
		chk(c_cpu, 8);
		chk(c_sys, 4);
		halt();
		periph_irq <= 8'h01;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(cpu_idle, 1'b1);
		periph_irq <= 8'h08;
		wait_idle(1'b0, 20);
		periph_irq <= 8'h00;
		wr(8'h00, 32'h0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(gv, 8'h7e);
		results();
	end
endmodule
`default_nettype wire

// >>> verif/pll_lock_model.sv
/*
 Behavioural PLL lock source facing the clock manager.
 Assumes one clock; lock returns LOCK_DLY+1 cycles after the PLL is powered.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_lock_model #(
	parameter int LOCK_DLY = 30
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic pll_on,
	output logic      pll_lock
);
	int cnt;
	// Lock drops at once when power goes, so a design that skips the wait is caught.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			pll_lock <= 1'b1;
		end else if (!pll_on) begin
			cnt <= 0;
			pll_lock <= 1'b0;
		end else if (cnt < LOCK_DLY) begin
			cnt <= cnt + 1;
		end else begin
			pll_lock <= 1'b1;
		end
	end
endmodule
`default_nettype wire
